// ==== inc/flm_params.svh ====
// constants of the fp immediate-load, flag-move and multiply unit
// How it works
// RULE_01 - upper load: imm to 31:16, zero 15:0
// RULE_02 - imm from word bits, low three pick register
// RULE_03 - alias upper load decodes as plain one
// RULE_04 - loads and flag move finish in one cycle
// RULE_05 - lower load: imm to 15:0, keep 31:16
// RULE_06 - flag move: fixed upper byte, select low byte
// RULE_07 - latched over/underflow selected drive overflow bit
// RULE_08 - negative flags selected drive negative bit
// RULE_09 - zero flags selected drive zero bit
// RULE_10 - test flag drives carry and test bits
// RULE_11 - unselected cpu status bits stay unchanged
// RULE_12 - flag move clears selected latched flags
// RULE_13 - no flag move in multiply delay slot
// RULE_14 - multiply two fp registers into third
// RULE_15 - multiply sets latched under/overflow flags only
// RULE_16 - multiply takes two cycles, one delay slot
// RULE_17 - delay slot must not touch multiply destination
// RULE_18 - fixed select bit order for each flag
`ifndef FLM_PARAMS_SVH
`define FLM_PARAMS_SVH

// register byte offsets
`define FLM_ADR_FPR_TOP 3'h0
`define FLM_ADR_STF 8'h20
`define FLM_ADR_IRQ_STAT 8'h24
`define FLM_ADR_IRQ_MASK 8'h28

// reset values
`define FLM_FPR_RST 32'h0000_0000
`define FLM_STF_RST 8'h00
`define FLM_IRQ_MASK_RST 4'h0

// opcodes of the first instruction word, and the multiply's field in the second word
`define FLM_OPC_LD_UPPER 13'h1D00
`define FLM_OPC_LD_LOWER 13'h1D01
`define FLM_OPC_FLAGS 8'hAD
`define FLM_OPC_MUL 16'hE700
`define FLM_OPC_MUL_MSW 7'h00

// flag positions in the fp status register and the select field
`define FLM_F_TEST 0
`define FLM_F_CMPI 1
`define FLM_F_ZI 2
`define FLM_F_ZF 3
`define FLM_F_NI 4
`define FLM_F_NF 5
`define FLM_F_LUF 6
`define FLM_F_LVF 7

// cpu status bit positions on the flag update port
`define FLM_C_OV 0
`define FLM_C_N 1
`define FLM_C_Z 2
`define FLM_C_C 3
`define FLM_C_TC 4

// interrupt status bits
`define FLM_I_OVF 0
`define FLM_I_UNF 1
`define FLM_I_HAZ 2
`define FLM_I_BAD 3

// multiplier exponent limits (biased sum)
`define FLM_EXP_BIAS 10'h07F
`define FLM_EXP_OVF 10'h17E

`endif

// ==== inc/flm_pkg.sv ====
// types shared by the fp load, flag-move and multiply unit
package flm_pkg;

    typedef enum logic [2:0] {
        FLM_OP_NONE = 3'b000,
        FLM_OP_LD_UPPER = 3'b001,
        FLM_OP_LD_LOWER = 3'b010,
        FLM_OP_FLAGS = 3'b011,
        FLM_OP_MUL = 3'b100,
        FLM_OP_BAD = 3'b101
    } flm_op_t;

endpackage

// ==== testbench/flm_cpu_model.sv ====
// host cpu status register fed by the flag update port
`timescale 1ns/1ps
module flm_cpu_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [4:0] we_in,
    input wire logic [4:0] val_in,
    output logic [4:0] st_out
);
    logic [4:0] st_q;
    assign st_out = st_q;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_q <= 5'h00;
        end else begin
            st_q <= (st_q & ~we_in) | (val_in & we_in);
        end
    end
endmodule // flm_cpu_model

// ==== testbench/flm_top_monitor.sv ====
// assertion checker for the fp load, flag-move and multiply unit
`timescale 1ns/1ps
module flm_top_monitor (
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [15:0] INSTR_LSW_IN,
    input wire logic [15:0] INSTR_MSW_IN,
    input wire logic INSTR_DONE_OUT,
    input wire logic MUL_DONE_OUT,
    input wire logic [4:0] CPU_FLAG_WE_OUT,
    input wire logic [4:0] CPU_FLAG_VAL_OUT,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic WB_ACK_OUT,
    input wire logic WB_ERR_OUT
);
    default clocking dc @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    wire [7:0] s = INSTR_LSW_IN[7:0];
    wire ld_w = INSTR_VALID_IN && INSTR_LSW_IN[15:4] == 12'hE80;
    wire fl_w = INSTR_VALID_IN && INSTR_LSW_IN[15:8] == 8'hAD;
    wire mul_w = INSTR_VALID_IN && INSTR_LSW_IN == 16'hE700 && INSTR_MSW_IN[15:9] == 7'h00;
    wire [4:0] we_w = {s[0], s[0], s[2] | s[3], s[4] | s[5], s[6] | s[7]};
    sequence s_load; ld_w; endsequence
    sequence s_flag; fl_w; endsequence
    sequence s_mul; mul_w; endsequence
    sequence s_mul_answer; !INSTR_DONE_OUT ##1 MUL_DONE_OUT; endsequence

    chk_load_done: assert property (s_load |=> INSTR_DONE_OUT)
        else $error("load not finished in one cycle");
    chk_flag_done: assert property (s_flag |=> INSTR_DONE_OUT)
        else $error("flag move not finished in one cycle");
    chk_flag_strobes: assert property (s_flag |=> CPU_FLAG_WE_OUT == $past(we_w))
        else $error("flag move strobes wrong status bits");
    chk_mul_latency: assert property (s_mul |=> s_mul_answer)
        else $error("multiply result not two cycles late");
    chk_mul_cause: assert property (MUL_DONE_OUT |-> $past(mul_w, 2))
        else $error("multiply done without multiply");
    chk_done_cause: assert property (INSTR_DONE_OUT |-> $past(ld_w || fl_w))
        else $error("done without load or flag move");
    chk_strobe_cause: assert property (CPU_FLAG_WE_OUT != 5'h00 |-> $past(fl_w))
        else $error("status strobe without flag move");
    chk_val_masked: assert property ((CPU_FLAG_VAL_OUT & ~CPU_FLAG_WE_OUT) == 5'h00)
        else $error("status value outside strobes");
    chk_bus_answer: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_ERR_OUT
        |=> WB_ACK_OUT != WB_ERR_OUT)
        else $error("bus request not answered once");
    chk_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack longer than one cycle");
    chk_read_idle: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
        else $error("read data without ack");
endmodule // flm_top_monitor

bind flm_top flm_top_monitor u_mon (
    .REF_CLK_IN(REF_CLK_IN), .RST_B_IN(RST_B_IN), .INSTR_VALID_IN(INSTR_VALID_IN),
    .INSTR_LSW_IN(INSTR_LSW_IN), .INSTR_MSW_IN(INSTR_MSW_IN), .INSTR_DONE_OUT(INSTR_DONE_OUT),
    .MUL_DONE_OUT(MUL_DONE_OUT), .CPU_FLAG_WE_OUT(CPU_FLAG_WE_OUT),
    .CPU_FLAG_VAL_OUT(CPU_FLAG_VAL_OUT), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .WB_ERR_OUT(WB_ERR_OUT)
);

// ==== testbench/tb_fpu_load_flag_multiply_ops.sv ====
// self-checking bench for the fp load, flag-move and multiply unit
`timescale 1ns/1ps
`include "flm_params.svh"
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t %s", $time, m); end end
module tb_fpu_load_flag_multiply_ops;
    logic clk = 1'b0, rst_b = 1'b0, vld = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, e;
    logic [15:0] lsw = 16'h0, msw = 16'h0;
    logic [7:0] adr = 8'h0, fpu_status_reg, sel;
    logic [3:0] bsel = 4'hF;
    logic [31:0] wdat = 32'h0, q, seed = 32'hF93C, fpr [8] = '{default: 32'h0};
    logic [4:0] hst = 5'h0, host_st;
    int fails = 0, n_compared = 0, ticks = 0;
    wire done, mdone, irq, ack, err;
    wire [4:0] fwe, fval;
    wire [31:0] rdat;

    flm_top dut (
        .REF_CLK_IN(clk), .RST_B_IN(rst_b), .INSTR_VALID_IN(vld), .INSTR_LSW_IN(lsw),
        .INSTR_MSW_IN(msw), .INSTR_DONE_OUT(done), .MUL_DONE_OUT(mdone),
        .CPU_FLAG_WE_OUT(fwe), .CPU_FLAG_VAL_OUT(fval), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(bsel), .WB_DAT_IN(wdat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .WB_ERR_OUT(err), .IRQ_OUT(irq)
    );
    flm_cpu_model u_host (.clk_in(clk), .rst_b_in(rst_b), .we_in(fwe), .val_in(fval),
        .st_out(host_st));

    function automatic [31:0] lfsr(input [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic [4:0] exp_we(input [7:0] s);
        return {s[0], s[0], s[2] | s[3], s[4] | s[5], s[6] | s[7]};
    endfunction
    function automatic [4:0] exp_val(input [7:0] s, input [7:0] f);
        return exp_we(s) & exp_we(f);
    endfunction

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wb(input bit w, input [7:0] a, input [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        q = rdat;
        e = err;
        if (n >= 20) fails++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdc(input [7:0] a, input [31:0] x);
        wb(1'b0, a, 32'h0);
        `CHK(q, x, "register read")
    endtask
    task automatic ins(input [15:0] l, input [15:0] m, input bit k = 1'b0);
        vld <= 1'b1;
        lsw <= l;
        msw <= m;
        @(posedge clk);
        if (!k) vld <= 1'b0;
    endtask
    task automatic ld(input bit lo, input [2:0] d, input [15:0] i, input bit k = 1'b0);
        fpr[d] = lo ? {fpr[d][31:16], i} : {i, 16'h0000};
        ins({lo ? `FLM_OPC_LD_LOWER : `FLM_OPC_LD_UPPER, i[15:13]}, {i[12:0], d}, k);
    endtask
    task automatic mul(input [2:0] a, input [2:0] b, input [2:0] c, input bit k);
        ins(16'hE700, {7'h00, c, b, a}, k);
    endtask

    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 5000) begin
            fails++;
            end_sim();
        end
    end

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 11; i++) rdc(8'(i * 4), 32'h0);
        wb(1'b0, 8'h40, 32'h0);
        `CHK(e, 1'b1, "unmapped access accepted")
        wb(1'b1, 8'h20, 32'h5A);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            ld(seed[19], seed[2:0], seed[18:3]);
            #1;
            `CHK(done, 1'b1, "load done")
            @(posedge clk);
        end
        for (int i = 0; i < 8; i++) rdc(8'(i * 4), fpr[i]);
        rdc(8'h20, 32'h5A);
        bsel <= 4'h3;
        wb(1'b1, 8'h1C, 32'hFFFFFFFF);
        bsel <= 4'hF;
        rdc(8'h1C, {fpr[7][31:16], 16'hFFFF});
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            sel = (i < 8) ? 8'(1 << i) : seed[15:8];
            fpu_status_reg = seed[7:0];
            wb(1'b1, 8'h20, {24'h0, fpu_status_reg});
            ins({8'hAD, sel}, seed[31:16]);
            hst = (hst & ~exp_we(sel)) | exp_val(sel, fpu_status_reg);
            #1;
            `CHK(fwe, exp_we(sel), "flag strobes")
            `CHK(fval, exp_val(sel, fpu_status_reg), "flag values")
            `CHK(done, 1'b1, "flag move done")
            @(posedge clk);
            rdc(8'h20, {24'h0, fpu_status_reg & ~(sel & 8'hC0)});
            `CHK(host_st, hst, "host status")
        end
        ld(1'b0, 3'd0, 16'h4000, 1'b1);
        ld(1'b0, 3'd1, 16'h4040, 1'b1);
        mul(3'd4, 3'd0, 3'd1, 1'b1);
        ld(1'b0, 3'd5, 16'h3F80);
        #1;
        `CHK(mdone, 1'b1, "multiply timing")
        `CHK(done, 1'b1, "delay slot load")
        wb(1'b1, 8'h20, 32'h3F);
        rdc(8'h10, 32'h40C00000);
        wb(1'b1, 8'h24, 32'hF);
        ld(1'b0, 3'd0, 16'h7F00, 1'b1);
        mul(3'd2, 3'd0, 3'd0, 1'b0);
        repeat (2) @(posedge clk);
        rdc(8'h08, 32'h7F800000);
        rdc(8'h20, 32'hBF);
        rdc(8'h24, 32'h1);
        wb(1'b1, 8'h28, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1, "irq not raised")
        wb(1'b1, 8'h28, 32'h0);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0, "irq not masked")
        wb(1'b1, 8'h28, 32'hF);
        wb(1'b1, 8'h24, 32'h1);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0, "irq not cleared")
        ld(1'b0, 3'd3, 16'h0080, 1'b1);
        mul(3'd2, 3'd3, 3'd3, 1'b0);
        repeat (2) @(posedge clk);
        rdc(8'h08, 32'h0);
        rdc(8'h24, 32'h2);
        rdc(8'h20, 32'hFF);
        wb(1'b1, 8'h24, 32'hF);
        mul(3'd6, 3'd1, 3'd1, 1'b1);
        ld(1'b0, 3'd6, 16'h1234);
        repeat (2) @(posedge clk);
        rdc(8'h24, 32'h4);
        rdc(8'h18, 32'h41100000);
        wb(1'b1, 8'h24, 32'hF);
        mul(3'd7, 3'd1, 3'd1, 1'b1);
        ins({8'hAD, 8'h00}, 16'h0000);
        repeat (2) @(posedge clk);
        rdc(8'h24, 32'h4);
        wb(1'b1, 8'h24, 32'hF);
        mul(3'd7, 3'd1, 3'd1, 1'b1);
        mul(3'd0, 3'd7, 3'd7, 1'b0);
        repeat (2) @(posedge clk);
        rdc(8'h24, 32'h4);
        wb(1'b1, 8'h24, 32'hF);
        ins(16'h0000, 16'h0000);
        repeat (2) @(posedge clk);
        rdc(8'h24, 32'h8);
        end_sim();
    end
endmodule // tb_fpu_load_flag_multiply_ops

// ==== verilog/flm_flag_move.sv ====
// flag select to cpu status bit mapping
`timescale 1ns/1ps
`include "flm_params.svh"

module flm_flag_move (
    input wire logic [7:0] sel_in,
    input wire logic [7:0] stf_in,
    output logic [4:0] we_out,
    output logic [4:0] val_out,
    output logic [7:0] clr_out
);
    import flm_pkg::*;

    wire luf_lvf_sel = sel_in[`FLM_F_LUF] | sel_in[`FLM_F_LVF];
    wire neg_sel = sel_in[`FLM_F_NF] | sel_in[`FLM_F_NI];
    wire zero_sel = sel_in[`FLM_F_ZF] | sel_in[`FLM_F_ZI];
    wire test_sel = sel_in[`FLM_F_TEST];

    // RULE_07 overflow from latched
    assign we_out[`FLM_C_OV] = luf_lvf_sel;
    assign val_out[`FLM_C_OV] = stf_in[`FLM_F_LUF] | stf_in[`FLM_F_LVF];
    // RULE_08 negative from either
    assign we_out[`FLM_C_N] = neg_sel;
    assign val_out[`FLM_C_N] = stf_in[`FLM_F_NF] | stf_in[`FLM_F_NI];
    // RULE_09 zero from either
    assign we_out[`FLM_C_Z] = zero_sel;
    assign val_out[`FLM_C_Z] = stf_in[`FLM_F_ZF] | stf_in[`FLM_F_ZI];
    // RULE_10 test to carry and tc
    assign we_out[`FLM_C_C] = test_sel;
    assign val_out[`FLM_C_C] = stf_in[`FLM_F_TEST];
    assign we_out[`FLM_C_TC] = test_sel;
    assign val_out[`FLM_C_TC] = stf_in[`FLM_F_TEST];

    // RULE_12 clear selected latched
    assign clr_out = {sel_in[`FLM_F_LVF], sel_in[`FLM_F_LUF], 6'h00};

endmodule // flm_flag_move

// ==== verilog/flm_fmul.sv ====
// two-stage single-precision multiplier
`timescale 1ns/1ps
`include "flm_params.svh"

module flm_fmul (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic start_in,
    input wire logic [31:0] a_in,
    input wire logic [31:0] b_in,
    input wire logic [2:0] dst_in,
    output logic vld_out,
    output logic [2:0] dst_out,
    output logic [31:0] res_out,
    output logic unf_out,
    output logic ovf_out
);
    import flm_pkg::*;

    logic [31:0] a_q;
    logic [31:0] b_q;
    logic [2:0] dst_q;
    logic vld_q;

    // RULE_16 operand stage
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            a_q <= 32'h0000_0000;
            b_q <= 32'h0000_0000;
            dst_q <= 3'h0;
            vld_q <= 1'b0;
        end else begin
            vld_q <= start_in;
            if (start_in) begin
                a_q <= a_in;
                b_q <= b_in;
                dst_q <= dst_in;
            end
        end
    end

    wire sgn = a_q[31] ^ b_q[31];
    wire [7:0] ea = a_q[30:23];
    wire [7:0] eb = b_q[30:23];
    // denormals count as zero, inf and nan as infinity
    wire zero_in = (ea == 8'h00) | (eb == 8'h00);
    wire inf_in = (ea == 8'hFF) | (eb == 8'hFF);
    wire [47:0] prod = {1'b1, a_q[22:0]} * {1'b1, b_q[22:0]};
    wire norm = prod[47];
    wire [22:0] frac = norm ? prod[46:24] : prod[45:23];
    wire rnd = norm ? prod[23] : prod[22];
    wire stk = norm ? (|prod[22:0]) : (|prod[21:0]);
    wire up = rnd & (stk | frac[0]);
    wire [23:0] frac_r = {1'b0, frac} + {23'h000000, up};
    wire [9:0] esum = {2'h0, ea} + {2'h0, eb} + {9'h000, norm} + {9'h000, frac_r[23]};
    wire [9:0] eout = esum - `FLM_EXP_BIAS;

    // RULE_15 range checks
    wire unf = ~zero_in & ~inf_in & (esum <= `FLM_EXP_BIAS);
    wire ovf = ~zero_in & ~inf_in & (esum >= `FLM_EXP_OVF);

    // RULE_14 product result
    assign res_out = (zero_in | unf) ? {sgn, 31'h0000_0000} :
                     (inf_in | ovf) ? {sgn, 8'hFF, 23'h000000} :
                     {sgn, eout[7:0], frac_r[22:0]};
    assign unf_out = vld_q & unf;
    assign ovf_out = vld_q & ovf;
    assign vld_out = vld_q;
    assign dst_out = dst_q;

endmodule // flm_fmul

// ==== verilog/flm_top.sv ====
// fp immediate-load, flag-move and multiply unit with wishbone registers
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "flm_params.svh"

module flm_top (
    input wire logic REF_CLK_IN,
    input wire logic RST_B_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [15:0] INSTR_LSW_IN,
    input wire logic [15:0] INSTR_MSW_IN,
    output logic INSTR_DONE_OUT,
    output logic MUL_DONE_OUT,
    output logic [4:0] CPU_FLAG_WE_OUT,
    output logic [4:0] CPU_FLAG_VAL_OUT,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    output logic WB_ERR_OUT,
    output logic IRQ_OUT
);
    import flm_pkg::*;

    // byte-lane merge for bus writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int k = 0; k < 4; k++) begin
            if (sel[k]) begin
                r[8*k +: 8] = new_v[8*k +: 8];
            end
        end
        return r;
    endfunction

    // match of a 3-bit register index, shared by write-back and slot checks
    function automatic logic idx_hit(input logic [2:0] idx,
                                     input logic [2:0] n);
        return idx == n;
    endfunction

    // -------------------------------------------------------------
    // instruction decode
    // -------------------------------------------------------------

    flm_op_t op;
    // RULE_03 alias shares encoding
    wire is_ld_upper = INSTR_LSW_IN[15:3] == `FLM_OPC_LD_UPPER;
    wire is_ld_lower = INSTR_LSW_IN[15:3] == `FLM_OPC_LD_LOWER;
    // RULE_06 fixed upper byte
    wire is_flags = INSTR_LSW_IN[15:8] == `FLM_OPC_FLAGS;
    wire is_mul = (INSTR_LSW_IN == `FLM_OPC_MUL) & (INSTR_MSW_IN[15:9] == `FLM_OPC_MUL_MSW);

    assign op = !INSTR_VALID_IN ? FLM_OP_NONE :
                is_ld_upper ? FLM_OP_LD_UPPER :
                is_ld_lower ? FLM_OP_LD_LOWER :
                is_flags ? FLM_OP_FLAGS :
                is_mul ? FLM_OP_MUL : FLM_OP_BAD;

    // RULE_02 immediate and register fields
    wire [15:0] imm = {INSTR_LSW_IN[2:0], INSTR_MSW_IN[15:3]};
    wire [2:0] dst = INSTR_MSW_IN[2:0];
    // RULE_14 source fields
    wire [2:0] src_b = INSTR_MSW_IN[5:3];
    wire [2:0] src_c = INSTR_MSW_IN[8:6];
    wire [7:0] flag_sel = INSTR_LSW_IN[7:0];

    wire do_ld_upper = op == FLM_OP_LD_UPPER;
    wire do_ld_lower = op == FLM_OP_LD_LOWER;
    wire do_flags = op == FLM_OP_FLAGS;
    wire do_mul = op == FLM_OP_MUL;
    wire do_bad = op == FLM_OP_BAD;

    // -------------------------------------------------------------
    // register file and status
    // -------------------------------------------------------------

    logic [31:0] fpr_q [0:7];
    logic [31:0] fpr_d [0:7];
    logic [7:0] stf_q;
    logic [7:0] stf_d;
    logic [3:0] irq_stat_q;
    logic [3:0] irq_stat_d;
    logic [3:0] irq_mask_q;
    logic [3:0] irq_mask_d;

    // -------------------------------------------------------------
    // multiplier
    // -------------------------------------------------------------

    logic mul_vld;
    logic [2:0] mul_dst;
    logic [31:0] mul_res;
    logic mul_unf;
    logic mul_ovf;

    // RULE_16 issue to two-stage unit
    flm_fmul u_fmul (
        .clk_in(REF_CLK_IN),
        .rst_b_in(RST_B_IN),
        .start_in(do_mul),
        .a_in(fpr_q[src_b]),
        .b_in(fpr_q[src_c]),
        .dst_in(dst),
        .vld_out(mul_vld),
        .dst_out(mul_dst),
        .res_out(mul_res),
        .unf_out(mul_unf),
        .ovf_out(mul_ovf)
    );

    // -------------------------------------------------------------
    // flag move
    // -------------------------------------------------------------

    logic [4:0] fm_we;
    logic [4:0] fm_val;
    logic [7:0] fm_clr;

    // RULE_18 select bit order
    flm_flag_move u_flag_move (
        .sel_in(flag_sel),
        .stf_in(stf_q),
        .we_out(fm_we),
        .val_out(fm_val),
        .clr_out(fm_clr)
    );

    // RULE_11 only selected bits written
    // values outside the strobes are forced low so the host sees clean zeros
    wire [4:0] cpu_we_d = do_flags ? fm_we : 5'h00;
    wire [4:0] cpu_val_d = do_flags ? (fm_val & fm_we) : 5'h00;

    // -------------------------------------------------------------
    // delay slot check
    // -------------------------------------------------------------

    // RULE_17 slot touches destination
    // mul_vld marks the cycle in which the delay-slot instruction is presented
    wire slot_dst_hit = (do_ld_upper | do_ld_lower | do_mul) & idx_hit(dst, mul_dst);
    wire slot_src_hit = do_mul & (idx_hit(src_b, mul_dst) | idx_hit(src_c, mul_dst));
    // RULE_13 flag move in slot
    wire slot_flags = do_flags;
    wire hazard = mul_vld & (slot_dst_hit | slot_src_hit | slot_flags);

    // -------------------------------------------------------------
    // wishbone slave
    // -------------------------------------------------------------

    logic ack_q;
    logic err_q;
    logic [31:0] dat_q;

    wire req = WB_CYC_IN & WB_STB_IN & ~ack_q & ~err_q;
    wire adr_fpr = (WB_ADR_IN[7:5] == `FLM_ADR_FPR_TOP) & (WB_ADR_IN[1:0] == 2'h0);
    wire adr_stf = WB_ADR_IN == `FLM_ADR_STF;
    wire adr_stat = WB_ADR_IN == `FLM_ADR_IRQ_STAT;
    wire adr_mask = WB_ADR_IN == `FLM_ADR_IRQ_MASK;
    wire adr_hit = adr_fpr | adr_stf | adr_stat | adr_mask;
    wire bus_wr = req & WB_WE_IN & adr_hit;
    wire [2:0] fpr_idx = WB_ADR_IN[4:2];

    wire [31:0] rd_data = adr_fpr ? fpr_q[fpr_idx] :
                          adr_stf ? {24'h000000, stf_q} :
                          adr_stat ? {28'h0000000, irq_stat_q} :
                          adr_mask ? {28'h0000000, irq_mask_q} : 32'h0000_0000;

    wire [31:0] stf_wr = lane_merge({24'h000000, stf_q}, WB_DAT_IN, WB_SEL_IN);
    wire [31:0] mask_wr = lane_merge({28'h0000000, irq_mask_q}, WB_DAT_IN, WB_SEL_IN);
    wire [3:0] w1c = (bus_wr & adr_stat & WB_SEL_IN[0]) ? WB_DAT_IN[3:0] : 4'h0;

    // a taken request is answered exactly one cycle later
    wire ack_d = req & adr_hit;
    wire err_d = req & ~adr_hit;
    // read data stands only in the answer cycle, zero otherwise
    wire [31:0] dat_d = req ? rd_data : 32'h0000_0000;

    // -------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------

    // multiply write beats a load to the same register
    for (genvar i = 0; i < 8; i++) begin : g_fpr
        wire hit = idx_hit(dst, 3'(i));
        wire bus_hit = bus_wr & adr_fpr & idx_hit(fpr_idx, 3'(i));
        wire mul_hit = mul_vld & idx_hit(mul_dst, 3'(i));
        // RULE_16 result lands after slot
        assign fpr_d[i] = mul_hit ? mul_res :
                          // RULE_01 upper load clears low
                          (do_ld_upper & hit) ? {imm, 16'h0000} :
                          // RULE_05 lower load keeps upper
                          (do_ld_lower & hit) ? {fpr_q[i][31:16], imm} :
                          bus_hit ? lane_merge(fpr_q[i], WB_DAT_IN, WB_SEL_IN) :
                          fpr_q[i];
    end

    wire [7:0] stf_base = (bus_wr & adr_stf) ? stf_wr[7:0] : stf_q;
    wire [7:0] stf_clr = do_flags ? fm_clr : 8'h00;
    wire [7:0] stf_set = {mul_ovf, mul_unf, 6'h00};
    // RULE_12 clear, but new event wins
    // RULE_15 latch multiply range flags
    assign stf_d = (stf_base & ~stf_clr) | stf_set;

    wire [3:0] irq_ev;
    assign irq_ev[`FLM_I_OVF] = mul_ovf;
    assign irq_ev[`FLM_I_UNF] = mul_unf;
    assign irq_ev[`FLM_I_HAZ] = hazard;
    assign irq_ev[`FLM_I_BAD] = do_bad;
    assign irq_stat_d = (irq_stat_q & ~w1c) | irq_ev;
    assign irq_mask_d = (bus_wr & adr_mask) ? mask_wr[3:0] : irq_mask_q;
    // built from next status and mask so the pin rises one edge after the event
    wire irq_d = |(irq_stat_d & irq_mask_d);

    // RULE_04 single-cycle completion
    wire done_d = do_ld_upper | do_ld_lower | do_flags;

    // -------------------------------------------------------------
    // state registers
    // -------------------------------------------------------------

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            for (int j = 0; j < 8; j++) begin
                fpr_q[j] <= `FLM_FPR_RST;
            end
        end else begin
            for (int j = 0; j < 8; j++) begin
                fpr_q[j] <= fpr_d[j];
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            stf_q <= `FLM_STF_RST;
            irq_stat_q <= 4'h0;
            irq_mask_q <= `FLM_IRQ_MASK_RST;
            IRQ_OUT <= 1'b0;
        end else begin
            stf_q <= stf_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            IRQ_OUT <= irq_d;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            INSTR_DONE_OUT <= 1'b0;
            MUL_DONE_OUT <= 1'b0;
            CPU_FLAG_WE_OUT <= 5'h00;
            CPU_FLAG_VAL_OUT <= 5'h00;
        end else begin
            INSTR_DONE_OUT <= done_d;
            MUL_DONE_OUT <= mul_vld;
            CPU_FLAG_WE_OUT <= cpu_we_d;
            CPU_FLAG_VAL_OUT <= cpu_val_d;
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            err_q <= err_d;
            dat_q <= dat_d;
        end
    end

    assign WB_ACK_OUT = ack_q;
    assign WB_ERR_OUT = err_q;
    assign WB_DAT_OUT = dat_q;

endmodule // flm_top
